// ==== mode_sysctl.sv ====
// Operating-mode select, mode monitor and system control register bank.
// Assumes CPU software on AXI4-Lite, straps from board pins.
// Behaviour
// RL1: Mode comes from three strap pins; 110 is mode 6, 111 is mode 7.
// RL2: Board keeps strap pins steady during operation.
// RL3: Mode 6 bus starts 8-bit, turns 16-bit when any area is 16-bit.
// RL4: Mode 7 gives no external access; all ports are general ports.
// RL5: Monitor bit 7 reads 1, bits 6 to 3 read 0, writes ignored.
// RL6: Monitor bits 2 to 0 show strap levels, read-only.
// RL7: Straps latch on monitor read; power-on reset clears, manual keeps. The latch drives nothing; reads and decode use the filtered straps.
// RL8: Control bits 5:4 pick interrupt mode; 01 and 11 prohibited.
// RL9: Control bit 3 picks NMI edge: 0 falling, 1 rising.
// RL10: Control bit 2 enables the manual reset pin.
// RL11: Control bit 0 enables on-chip RAM, resets to 1.
// RL12: Control bit 7 read/write zero-reset; bits 6 and 1 read 0.
// RL13: Mode 6 ports A, B, C are inputs right after reset.
// RL14: Address-enable bits gate A23..A8; disabled lines follow direction bits.
// RL15: Mode 6 port C drives A7..A0 where direction bit is 1.
// RL16: Mode 6 port D data, F control; port E data only in 16-bit mode.
// RL17: Both modes address 16 Mbyte, advanced mode, on-chip ROM valid.
// RL18: F7 control in mode 6, port in mode 7; F6..F4 likewise.
// RL19: Manual reset keeps bus controller and port state.
// RL20: Control register reads 0x01 after power-on reset.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module mode_sysctl
  import mode_sysctl_pkg::*;
(
  input  wire logic                 CLK_I,
  input  wire logic                 RST_B_I,
  input  wire logic                 MANUAL_RESET_PIN_B_I,
  input  wire logic [2:0]           MODE_STRAP_PINS_I,
  input  wire mode_sysctl_pkg::port_dir_t PORT_DIR_I,
  input  wire logic [ADDR_W-1:0]    AWADDR_I,
  input  wire logic                 AWVALID_I,
  output logic                      AWREADY_O,
  input  wire logic [31:0]          WDATA_I,
  input  wire logic [3:0]           WSTRB_I,
  input  wire logic                 WVALID_I,
  output logic                      WREADY_O,
  output logic [1:0]                BRESP_O,
  output logic                      BVALID_O,
  input  wire logic                 BREADY_I,
  input  wire logic [ADDR_W-1:0]    ARADDR_I,
  input  wire logic                 ARVALID_I,
  output logic                      ARREADY_O,
  output logic [31:0]               RDATA_O,
  output logic [1:0]                RRESP_O,
  output logic                      RVALID_O,
  input  wire logic                 RREADY_I,
  output logic                      EXPANSION_MODE_O,
  output logic                      WIDE_BUS_O,
  output logic [1:0]                IRQ_CTRL_MODE_O,
  output logic                      NMI_EDGE_SELECT_O,
  output logic                      MANUAL_RESET_REQ_O,
  output logic                      ONCHIP_RAM_ENABLE_O,
  output mode_sysctl_pkg::port_func_t PORT_FUNC_O
);
  import mode_sysctl_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] strap_s1_reg, strap_s2_reg, strap_s3_reg, strap_reg;
  logic [2:0] manual_reset_pin_sh_reg;
  logic       manual_reset_pin_b_reg;

  always_ff @(posedge CLK_I)
  begin
    strap_s1_reg <= MODE_STRAP_PINS_I;
    strap_s2_reg <= strap_s1_reg;
    strap_s3_reg <= strap_s2_reg;
    if (strap_s2_reg == strap_s3_reg)
    begin
      strap_reg <= strap_s3_reg;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      manual_reset_pin_sh_reg <= 3'h7;
      manual_reset_pin_b_reg  <= 1'h1;
    end
    else
    begin
      manual_reset_pin_sh_reg <= {manual_reset_pin_sh_reg[1:0], MANUAL_RESET_PIN_B_I};
      if (manual_reset_pin_sh_reg[1] == manual_reset_pin_sh_reg[2])
      begin
        manual_reset_pin_b_reg <= manual_reset_pin_sh_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset split
  // ----------------------------------------------------------------
  logic sysctl_reg_manual_reset_pin_en;
  logic manual_rst;
  logic manual_hold_reg;
  // Reload clears the enable bit, so hold the reset until the pin rises
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      manual_hold_reg <= 1'h0;
    end
    else
    begin
      manual_hold_reg <= manual_rst;
    end
  end

  // Manual reset only counts while power-on reset is released
  assign manual_rst = !manual_reset_pin_b_reg && (sysctl_reg_manual_reset_pin_en || manual_hold_reg); // RL10 RL19

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic              aw_held_reg, w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wdata_reg;
  logic              wstrb0_reg;
  logic              do_write;

  assign do_write = aw_held_reg && w_held_reg && !BVALID_O;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      aw_held_reg <= 1'h0;
      w_held_reg  <= 1'h0;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'h0;
      AWREADY_O   <= 1'h0;
      WREADY_O    <= 1'h0;
      BVALID_O    <= 1'h0;
      BRESP_O     <= RESP_OKAY;
    end
    else
    begin
      AWREADY_O <= !aw_held_reg && !(AWVALID_I && AWREADY_O);
      WREADY_O  <= !w_held_reg && !(WVALID_I && WREADY_O);
      if (AWVALID_I && AWREADY_O)
      begin
        aw_held_reg <= 1'h1;
        awaddr_reg  <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_held_reg <= 1'h1;
        wdata_reg  <= WDATA_I[7:0];
        wstrb0_reg <= WSTRB_I[0];
      end
      if (do_write)
      begin
        aw_held_reg <= 1'h0;
        w_held_reg  <= 1'h0;
        BVALID_O    <= 1'h1;
        BRESP_O     <= (awaddr_reg == ADDR_MODE_MONITOR ||
                        awaddr_reg == ADDR_SYSTEM_CONTROL ||
                        awaddr_reg == ADDR_PORT_FUNCTION ||
                        awaddr_reg == ADDR_BUS_CONFIG) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID_O && BREADY_I)
      begin
        BVALID_O <= 1'h0;
      end
    end
  end

  logic wr_en;
  assign wr_en = do_write && wstrb0_reg;

  // ----------------------------------------------------------------
  // System control register
  // ----------------------------------------------------------------
  logic [7:0] sysctl_reg;
  assign sysctl_reg_manual_reset_pin_en = sysctl_reg[BIT_MANUAL_RESET_PIN_EN];

  // Manual reset reinitialises this register too; it is not a port
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I || manual_rst)
    begin
      sysctl_reg <= SYSCTL_RESET; // RL11 RL20
    end
    else if (wr_en && awaddr_reg == ADDR_SYSTEM_CONTROL)
    begin
      sysctl_reg <= wdata_reg & SYSCTL_WMASK; // RL8 RL9 RL12
    end
  end

  // ----------------------------------------------------------------
  // Port function and bus width; kept over a manual reset
  // ----------------------------------------------------------------
  logic [3:0] addr_en_reg;
  logic [7:0] area_wide_reg;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      addr_en_reg   <= ADDR_EN_RESET; // RL19
      area_wide_reg <= AREA_WIDE_RESET; // RL3
    end
    else if (wr_en && awaddr_reg == ADDR_PORT_FUNCTION)
    begin
      addr_en_reg <= wdata_reg[3:0];
    end
    else if (wr_en && awaddr_reg == ADDR_BUS_CONFIG)
    begin
      area_wide_reg <= wdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // Mode latch and read path
  // ----------------------------------------------------------------
  logic [2:0] mode_latch_reg;
  logic       rd_take;
  logic [7:0] rd_byte;
  assign rd_take = ARVALID_I && ARREADY_O;

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      mode_latch_reg <= 3'h0; // RL7
    end
    else if (rd_take && ARADDR_I == ADDR_MODE_MONITOR)
    begin
      mode_latch_reg <= strap_reg; // RL6 RL7
    end
  end

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (ARADDR_I)
      ADDR_MODE_MONITOR:   rd_byte = MONITOR_FIXED | {5'h00, strap_reg}; // RL5 RL6
      ADDR_SYSTEM_CONTROL: rd_byte = sysctl_reg; // RL12
      ADDR_PORT_FUNCTION:  rd_byte = {4'h0, addr_en_reg};
      ADDR_BUS_CONFIG:     rd_byte = area_wide_reg;
      default:             rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      ARREADY_O <= 1'h0;
      RVALID_O  <= 1'h0;
      RDATA_O   <= ZERO32;
      RRESP_O   <= RESP_OKAY;
    end
    else
    begin
      ARREADY_O <= !RVALID_O && !rd_take;
      if (rd_take)
      begin
        RVALID_O <= 1'h1;
        RDATA_O  <= {24'h000000, rd_byte};
        RRESP_O  <= (ARADDR_I == ADDR_MODE_MONITOR ||
                     ARADDR_I == ADDR_SYSTEM_CONTROL ||
                     ARADDR_I == ADDR_PORT_FUNCTION ||
                     ARADDR_I == ADDR_BUS_CONFIG) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (RVALID_O && RREADY_I)
      begin
        RVALID_O <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and pin functions
  // ----------------------------------------------------------------
  logic exp_mode;
  logic wide;
  // Any strap other than 110 runs as single-chip, the safe choice
  assign exp_mode = (strap_reg == MODE_EXPANSION); // RL1 RL4 RL17
  assign wide     = exp_mode && (area_wide_reg != AREA_WIDE_RESET); // RL3

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      EXPANSION_MODE_O    <= 1'h0;
      WIDE_BUS_O          <= 1'h0;
      IRQ_CTRL_MODE_O     <= 2'h0;
      NMI_EDGE_SELECT_O   <= 1'h0;
      MANUAL_RESET_REQ_O  <= 1'h0;
      ONCHIP_RAM_ENABLE_O <= 1'h1;
      PORT_FUNC_O         <= '0; // RL13
    end
    else
    begin
      EXPANSION_MODE_O    <= exp_mode;
      WIDE_BUS_O          <= wide;
      IRQ_CTRL_MODE_O     <= {sysctl_reg[BIT_IRQ_HI], sysctl_reg[BIT_IRQ_LO]}; // RL8
      NMI_EDGE_SELECT_O   <= sysctl_reg[BIT_NMI_EDGE]; // RL9
      MANUAL_RESET_REQ_O  <= manual_rst; // RL10
      ONCHIP_RAM_ENABLE_O <= sysctl_reg[BIT_RAM_EN]; // RL11
      // Direction bits alone steer A and B; address enable picks function
      PORT_FUNC_O.oe_a     <= PORT_DIR_I.ddr_a; // RL14
      PORT_FUNC_O.oe_b     <= PORT_DIR_I.ddr_b; // RL14
      PORT_FUNC_O.oe_c     <= PORT_DIR_I.ddr_c; // RL15
      PORT_FUNC_O.addr_a_c <= exp_mode; // RL15
      PORT_FUNC_O.addr_en  <= exp_mode ? addr_en_reg : 4'h0; // RL14 RL4
      PORT_FUNC_O.data_d   <= exp_mode; // RL16
      PORT_FUNC_O.data_e   <= wide; // RL16
      PORT_FUNC_O.ctrl_f7  <= exp_mode; // RL18
      PORT_FUNC_O.ctrl_f64 <= exp_mode; // RL18
    end
  end
endmodule : mode_sysctl
`default_nettype wire

// ==== mode_sysctl_pkg.sv ====
// Package for the operating-mode and system-control register bank.
// Assumes a 32-bit AXI4-Lite register bus and 8-bit registers in low bits.
`default_nettype none
package mode_sysctl_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE_MONITOR   = 4'h0;
  localparam logic [3:0] ADDR_SYSTEM_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_PORT_FUNCTION  = 4'h8;
  localparam logic [3:0] ADDR_BUS_CONFIG     = 4'hc;
  localparam int         ADDR_W              = 4;
  // ----------------------------------------------------------------
  // Field layout and values
  // ----------------------------------------------------------------
  localparam logic [7:0] MONITOR_FIXED       = 8'h80;
  localparam logic [7:0] SYSCTL_RESET        = 8'h01;
  localparam logic [7:0] SYSCTL_WMASK        = 8'hbd;
  localparam logic [3:0] ADDR_EN_RESET       = 4'h0;
  localparam logic [7:0] AREA_WIDE_RESET     = 8'h00;
  localparam logic [2:0] MODE_EXPANSION      = 3'h6;
  localparam logic [2:0] MODE_SINGLE_CHIP    = 3'h7;
  localparam int         BIT_RAM_EN          = 0;
  localparam int         BIT_MANUAL_RESET_PIN_EN         = 2;
  localparam int         BIT_NMI_EDGE        = 3;
  localparam int         BIT_IRQ_LO          = 4;
  localparam int         BIT_IRQ_HI          = 5;
  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;
  localparam logic [31:0] ZERO32             = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] ddr_a;
    logic [7:0] ddr_b;
    logic [7:0] ddr_c;
  } port_dir_t;

  typedef struct packed {
    logic [7:0] oe_a;
    logic [7:0] oe_b;
    logic [7:0] oe_c;
    logic       addr_a_c;
    logic [3:0] addr_en;
    logic       data_d;
    logic       data_e;
    logic       ctrl_f7;
    logic       ctrl_f64;
  } port_func_t;
endpackage : mode_sysctl_pkg
`default_nettype wire

// ==== board_straps.sv ====
// Board model: mode straps and manual reset push-button.
// Assumes the bench changes the strap code only while power-on reset is held.
`default_nettype none
module board_straps
(
  input  wire logic       press_i,
  input  wire logic [2:0] code_i,
  output logic            manual_reset_pin_b_o,
  output logic [2:0]      straps_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled-up button, low only while pressed
  assign manual_reset_pin_b_o = !press_i;
  assign straps_o = code_i;
endmodule : board_straps
`default_nettype wire

// ==== mode_sysctl_monitor.sv ====
// Checker for the mode and system-control bank.
// Assumes it is bound into mode_sysctl and sees only its ports.
`default_nettype none
module mode_sysctl_monitor
  import mode_sysctl_pkg::*;
(
  input wire logic                        CLK_I,
  input wire logic                        RST_B_I,
  input wire logic [2:0]                  MODE_STRAP_PINS_I,
  input wire mode_sysctl_pkg::port_dir_t  PORT_DIR_I,
  input wire logic                        ARVALID_I,
  input wire logic                        ARREADY_O,
  input wire logic                        RREADY_I,
  input wire logic                        RVALID_O,
  input wire logic [31:0]                 RDATA_O,
  input wire logic                        BREADY_I,
  input wire logic                        BVALID_O,
  input wire logic [1:0]                  BRESP_O,
  input wire logic                        EXPANSION_MODE_O,
  input wire logic                        WIDE_BUS_O,
  input wire logic                        ONCHIP_RAM_ENABLE_O,
  input wire logic [1:0]                  IRQ_CTRL_MODE_O,
  input wire mode_sysctl_pkg::port_func_t PORT_FUNC_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ----------------------------------------------------------------
  // Strap decode, allowing for the filter delay
  // ----------------------------------------------------------------
  sequence s_strap6;
    (RST_B_I && MODE_STRAP_PINS_I == 3'h6) [*8];
  endsequence
  sequence s_strap7;
    (RST_B_I && MODE_STRAP_PINS_I == 3'h7) [*8];
  endsequence
  a_strap_six : assert property (s_strap6 |-> EXPANSION_MODE_O && PORT_FUNC_O.ctrl_f7
    && PORT_FUNC_O.ctrl_f64) else $error("mode 6 pin roles wrong");
  a_strap_seven : assert property (s_strap7 |-> !EXPANSION_MODE_O && !PORT_FUNC_O.data_d
    && PORT_FUNC_O.addr_en == 4'h0) else $error("mode 7 not single-chip");
  a_wide_needs_exp : assert property ((WIDE_BUS_O || PORT_FUNC_O.data_e) |-> EXPANSION_MODE_O)
    else $error("wide bus outside mode 6");
  a_reset_values : assert property (disable iff (1'b0) !RST_B_I |=> ONCHIP_RAM_ENABLE_O
    && IRQ_CTRL_MODE_O == 2'h0) else $error("reset values wrong");
  a_port_dir_copy : assert property ($past(RST_B_I) |-> PORT_FUNC_O.oe_c ==
    $past(PORT_DIR_I.ddr_c)) else $error("port C enable not following direction");
  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  a_read_answer : assert property (ARVALID_I && ARREADY_O |=> RVALID_O
    && RDATA_O[31:8] == 24'h0) else $error("read answer late or upper bits set");
  a_rdata_hold : assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped before taken");
  a_bresp_hold : assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped before taken");
endmodule : mode_sysctl_monitor
bind mode_sysctl mode_sysctl_monitor mon (.*);
`default_nettype wire

// ==== mode_sysctl_test.sv ====
// Bench for the mode and system-control bank over AXI4-Lite.
// Assumes board_straps drives the straps and the manual reset pin.
`default_nettype none
module mode_sysctl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mode_sysctl_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, press = 1'b0, manual_reset_pin_b, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
  logic rvalid, exp_o, wide_o, nmi_o, mreq_o, ram_o;
  logic [2:0] code = 3'h7, straps;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, irq_o;
  port_dir_t dir = '0;
  port_func_t pf;
  int err_count = 0, n_tests = 0;
  always #5 clk = ~clk;
  board_straps board (.press_i(press), .code_i(code), .manual_reset_pin_b_o(manual_reset_pin_b), .straps_o(straps));
  mode_sysctl dut (.CLK_I(clk), .RST_B_I(rst_b), .MANUAL_RESET_PIN_B_I(manual_reset_pin_b),
    .MODE_STRAP_PINS_I(straps), .PORT_DIR_I(dir), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .EXPANSION_MODE_O(exp_o),
    .WIDE_BUS_O(wide_o), .IRQ_CTRL_MODE_O(irq_o), .NMI_EDGE_SELECT_O(nmi_o),
    .MANUAL_RESET_REQ_O(mreq_o), .ONCHIP_RAM_ENABLE_O(ram_o), .PORT_FUNC_O(pf));
  // ----------------------------------------------------------------
  // Bus tasks and compare
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    bready <= 1'b0;
    check(32'(bresp), 32'(RESP_OKAY));
    if (n >= 50) err_count++;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    rready <= 1'b0;
    check(rdata, {24'h0, e});
    if (n >= 50) err_count++;
  endtask : rc
  task automatic summarize();
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(ram_o), 32'h1);
    rc(ADDR_SYSTEM_CONTROL, 8'h01);
    rc(ADDR_MODE_MONITOR, 8'h87);
    check(32'(exp_o), 32'h0);
    check(32'(pf.addr_en), 32'h0);
    check(32'(pf.ctrl_f7), 32'h0);
    wr(ADDR_MODE_MONITOR, 32'hff);
    rc(ADDR_MODE_MONITOR, 8'h87);
    wr(ADDR_SYSTEM_CONTROL, 32'hff);
    rc(ADDR_SYSTEM_CONTROL, 8'hbd);
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_SYSTEM_CONTROL, 32'(m) << 4);
      rc(ADDR_SYSTEM_CONTROL, 8'(m) << 4);
      check(32'(irq_o), 32'(m));
    end
    check(32'(ram_o), 32'h0);
    wr(ADDR_SYSTEM_CONTROL, 32'h08);
    rc(ADDR_SYSTEM_CONTROL, 8'h08);
    check(32'(nmi_o), 32'h1);
    press <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(mreq_o), 32'h0);
    press <= 1'b0;
    // Straps move only under power-on reset
    rst_b <= 1'b0;
    code <= 3'h6;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(nmi_o), 32'h0);
    rc(ADDR_MODE_MONITOR, 8'h86);
    check(32'(exp_o), 32'h1);
    check(32'(wide_o), 32'h0);
    check(32'(pf.data_e), 32'h0);
    check(32'(pf.oe_a), 32'h0);
    check(32'(pf.data_d), 32'h1);
    dir.ddr_c <= 8'h5a;
    wr(ADDR_PORT_FUNCTION, 32'h0a);
    wr(ADDR_BUS_CONFIG, 32'h01);
    rc(ADDR_PORT_FUNCTION, 8'h0a);
    check(32'(pf.oe_c), 32'h5a);
    check(32'(pf.addr_en), 32'ha);
    check(32'(wide_o), 32'h1);
    check(32'(pf.data_e), 32'h1);
    wr(ADDR_SYSTEM_CONTROL, 32'h0c);
    press <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(mreq_o), 32'h1);
    press <= 1'b0;
    repeat (6) @(posedge clk);
    rc(ADDR_SYSTEM_CONTROL, 8'h01);
    rc(ADDR_PORT_FUNCTION, 8'h0a);
    rc(ADDR_MODE_MONITOR, 8'h86);
    check(32'(wide_o), 32'h1);
    summarize();
  end
  // Whole run is well under 2000 cycles
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule : mode_sysctl_test
`default_nettype wire
